// file: common/ews_pkg.sv
// Shared constants and types of the external bus wait-state controller.
package ews_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [7:0]  EWS_IDX_WAIT_COUNT  = 8'h28;
  localparam logic [7:0]  EWS_IDX_BANK_SWITCH = 8'h29;
  localparam logic [7:0]  EWS_IDX_WAIT_CTRL   = 8'h2B;
  localparam logic [7:0]  EWS_IDX_STATUS      = 8'h2C;
  localparam logic [11:0] EWS_ADDR_WAIT_COUNT  = {2'h0, EWS_IDX_WAIT_COUNT, 2'h0};
  localparam logic [11:0] EWS_ADDR_BANK_SWITCH = {2'h0, EWS_IDX_BANK_SWITCH, 2'h0};
  localparam logic [11:0] EWS_ADDR_WAIT_CTRL   = {2'h0, EWS_IDX_WAIT_CTRL, 2'h0};
  localparam logic [11:0] EWS_ADDR_STATUS      = {2'h0, EWS_IDX_STATUS, 2'h0};

  // Reset values.
  localparam logic [15:0] EWS_WAIT_COUNT_RST  = 16'h7FFF;
  localparam logic [15:0] EWS_BANK_SWITCH_RST = 16'h0000;
  localparam logic [15:0] EWS_WAIT_CTRL_RST   = 16'h0000;

  // Field layout.
  localparam int unsigned EWS_NUM_RANGES     = 5;
  localparam int unsigned EWS_FLD_W          = 3;
  localparam int unsigned EWS_MULT_BIT       = 0;
  localparam int unsigned EWS_DS2PS_BIT      = 1;
  localparam int unsigned EWS_BANK_MASK_LSB  = 12;
  localparam int unsigned EWS_ST_BUSY_BIT    = 0;
  localparam int unsigned EWS_ST_GATED_BIT   = 1;
  localparam int unsigned EWS_ST_READY_BIT   = 2;
  localparam logic [2:0]  EWS_RANGE_IO       = 3'h4;

  // Longest software wait in machine cycles.
  localparam logic [3:0]  EWS_MAX_WAIT       = 4'hE;

  typedef enum logic [1:0]
  {
    EWS_SP_PROG = 2'b00,
    EWS_SP_DATA = 2'b01,
    EWS_SP_IO   = 2'b10
  } ews_space_t;

  typedef enum logic [1:0]
  {
    EWS_ST_IDLE   = 2'b00,
    EWS_ST_BANK   = 2'b01,
    EWS_ST_ACCESS = 2'b10
  } ews_state_t;

endpackage

// file: rtl/ews_wait_timer.sv
// Software wait-state down-counter of the external bus controller.
`timescale 1ns/100ps
module ews_wait_timer
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       start,
  input  wire logic       enable,
  input  wire logic [3:0] count,
  // Status
  output logic            expired
);
  import ews_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  // While every range is at zero waits the counter never loads, so it sits still and draws no toggle power.
  always_comb
  begin
    cnt_next = cnt_reg;
    if (start && enable)
    begin
      cnt_next = count;
    end
    else if (cnt_reg != 4'h0)
    begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  end

  assign expired = (cnt_reg == 4'h0);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TIMER_MAX: assert property (cnt_reg <= EWS_MAX_WAIT)
    else $error("Wait counter above the longest software wait.");
  AST_TIMER_GATED: assert property (!enable && expired |=> expired)
    else $error("Wait counter moved while generator is gated.");
  AST_TIMER_LOAD: assert property (start && enable |=> cnt_reg == $past(count))
    else $error("Wait counter did not load the selected count.");
endmodule

// file: rtl/ews_bus_ctrl.sv
// External bus wait-state controller with APB register access.
// Contract
// - Software waits stretch cycles up to fourteen.
// - Slow device holds ready low to extend.
// - All-zero wait fields stop the wait counter.
// - Five 3-bit wait fields, one per range.
// - Multiplier bit scales waits by one or two.
// - Reset gives seven waits on every range.
// - One extra cycle on bank crossings.
// - Optional extra cycle from data to program.
// - Bank register sets bank compare size.
// - I/O space holds 64K ports.
// - I/O strobe marks port reads and writes.
// - External address bus is twenty bits.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module ews_bus_ctrl
(
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core access request
  input  wire logic              core_req,
  input  wire logic [19:0]       core_addr,
  input  wire ews_pkg::ews_space_t core_space,
  input  wire logic              core_write,
  output logic                   core_ack,
  // External bus pins
  output logic      [19:0]       ext_addr,
  output logic                   ext_read_n_write,
  output logic                   prog_strobe_n,
  output logic                   data_strobe_n,
  output logic                   io_space_strobe_n,
  input  wire logic              ext_ready
);
  import ews_pkg::*;

  logic [15:0] ext_wait_count_reg, ext_wait_count_next;
  logic [15:0] bank_switch_control_reg, bank_switch_control_next;
  logic [15:0] wait_control_reg, wait_control_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  ews_state_t  state_reg, state_next;
  logic [19:0] acc_addr_reg, acc_addr_next;
  ews_space_t  acc_space_reg, acc_space_next;
  logic        acc_write_reg, acc_write_next;
  logic [19:0] prev_addr_reg, prev_addr_next;
  ews_space_t  prev_space_reg, prev_space_next;
  logic        have_prev_reg, have_prev_next;
  logic [19:0] ext_addr_reg, ext_addr_next;
  logic        rnw_reg, rnw_next;
  logic        prog_stb_n_reg, prog_stb_n_next;
  logic        data_stb_n_reg, data_stb_n_next;
  logic        io_stb_n_reg, io_stb_n_next;
  logic        ack_reg, ack_next;

  logic        rdy_s1_reg, rdy_s2_reg, rdy_s3_reg;
  logic        ready_stable_reg, ready_stable_next;

  logic [2:0]  wait_fld [EWS_NUM_RANGES];
  logic [EWS_NUM_RANGES-1:0] fld_zero;
  logic        gen_gated;
  logic [19:0] sel_addr;
  ews_space_t  sel_space;
  logic [2:0]  sel_range;
  logic [3:0]  eff_count;
  logic        bank_cross;
  logic        timer_start;
  logic        timer_expired;
  logic        apb_write;
  logic        apb_read;

  // Five wait fields packed from the bottom of the wait-count register.
  genvar gi;
  generate
    for (gi = 0; gi < EWS_NUM_RANGES; gi++)
    begin : g_fld
      assign wait_fld[gi] = ext_wait_count_reg[gi*EWS_FLD_W +: EWS_FLD_W];
      assign fld_zero[gi] = (wait_fld[gi] == 3'h0);
    end
  endgenerate

  assign gen_gated = &fld_zero;

  // In idle the count is worked out from the incoming request so the timer loads on the entry edge.
  assign sel_addr  = (state_reg == EWS_ST_IDLE) ? core_addr : acc_addr_reg;
  assign sel_space = (state_reg == EWS_ST_IDLE) ? core_space : acc_space_reg;
  assign sel_range = (sel_space == EWS_SP_IO) ? EWS_RANGE_IO : {1'b0, sel_space[0], sel_addr[15]};
  assign eff_count = wait_control_reg[EWS_MULT_BIT] ? {wait_fld[sel_range], 1'b0}
                                                    : {1'b0, wait_fld[sel_range]};

  // Only the upper bank bits selected by the mask are compared.
  assign bank_cross = have_prev_reg &&
    (((prev_space_reg == core_space) && (core_space != EWS_SP_IO) &&
      (((prev_addr_reg[15:12] ^ core_addr[15:12]) &
        bank_switch_control_reg[EWS_BANK_MASK_LSB +: 4]) != 4'h0)) ||
     (bank_switch_control_reg[EWS_DS2PS_BIT] &&
      (prev_space_reg == EWS_SP_DATA) && (core_space == EWS_SP_PROG)));

  ews_wait_timer u_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (timer_start),
    .enable  (!gen_gated),
    .count   (eff_count),
    .expired (timer_expired)
  );

  // Ready passes three flops; a level counts once the last two agree.
  always_comb
  begin
    ready_stable_next = (rdy_s2_reg == rdy_s3_reg) ? rdy_s3_reg : ready_stable_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_s1_reg       <= 1'b0;
      rdy_s2_reg       <= 1'b0;
      rdy_s3_reg       <= 1'b0;
      ready_stable_reg <= 1'b0;
    end
    else
    begin
      rdy_s1_reg       <= ext_ready;
      rdy_s2_reg       <= rdy_s1_reg;
      rdy_s3_reg       <= rdy_s2_reg;
      ready_stable_reg <= ready_stable_next;
    end
  end

  // Access sequencer.
  always_comb
  begin
    state_next      = state_reg;
    acc_addr_next   = acc_addr_reg;
    acc_space_next  = acc_space_reg;
    acc_write_next  = acc_write_reg;
    prev_addr_next  = prev_addr_reg;
    prev_space_next = prev_space_reg;
    have_prev_next  = have_prev_reg;
    ext_addr_next   = ext_addr_reg;
    rnw_next        = rnw_reg;
    prog_stb_n_next = prog_stb_n_reg;
    data_stb_n_next = data_stb_n_reg;
    io_stb_n_next   = io_stb_n_reg;
    ack_next        = 1'b0;
    timer_start     = 1'b0;
    case (state_reg)
      EWS_ST_IDLE:
      begin
        // The ack cycle is never a take edge, so a request still standing from the last access is not taken twice.
        if (core_req && !ack_reg)
        begin
          acc_addr_next  = core_addr;
          acc_space_next = core_space;
          acc_write_next = core_write;
          rnw_next       = !core_write;
          // Port space is 64K, so the page bits stay low on I/O cycles.
          ext_addr_next  = (core_space == EWS_SP_IO) ? {4'h0, core_addr[15:0]} : core_addr;
          if (bank_cross)
          begin
            state_next = EWS_ST_BANK;
          end
          else
          begin
            state_next      = EWS_ST_ACCESS;
            timer_start     = 1'b1;
            prog_stb_n_next = (core_space != EWS_SP_PROG);
            data_stb_n_next = (core_space != EWS_SP_DATA);
            io_stb_n_next   = (core_space != EWS_SP_IO);
          end
        end
      end
      EWS_ST_BANK:
      begin
        state_next      = EWS_ST_ACCESS;
        timer_start     = 1'b1;
        prog_stb_n_next = (acc_space_reg != EWS_SP_PROG);
        data_stb_n_next = (acc_space_reg != EWS_SP_DATA);
        io_stb_n_next   = (acc_space_reg != EWS_SP_IO);
      end
      EWS_ST_ACCESS:
      begin
        // Ready is looked at only once the software waits have run out.
        if (timer_expired && ready_stable_reg)
        begin
          state_next      = EWS_ST_IDLE;
          ack_next        = 1'b1;
          prog_stb_n_next = 1'b1;
          data_stb_n_next = 1'b1;
          io_stb_n_next   = 1'b1;
          have_prev_next  = 1'b1;
          prev_addr_next  = acc_addr_reg;
          prev_space_next = acc_space_reg;
        end
      end
      default:
      begin
        state_next = EWS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg      <= EWS_ST_IDLE;
      acc_addr_reg   <= 20'h00000;
      acc_space_reg  <= EWS_SP_PROG;
      acc_write_reg  <= 1'b0;
      prev_addr_reg  <= 20'h00000;
      prev_space_reg <= EWS_SP_PROG;
      have_prev_reg  <= 1'b0;
      ext_addr_reg   <= 20'h00000;
      rnw_reg        <= 1'b1;
      prog_stb_n_reg <= 1'b1;
      data_stb_n_reg <= 1'b1;
      io_stb_n_reg   <= 1'b1;
      ack_reg        <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      acc_addr_reg   <= acc_addr_next;
      acc_space_reg  <= acc_space_next;
      acc_write_reg  <= acc_write_next;
      prev_addr_reg  <= prev_addr_next;
      prev_space_reg <= prev_space_next;
      have_prev_reg  <= have_prev_next;
      ext_addr_reg   <= ext_addr_next;
      rnw_reg        <= rnw_next;
      prog_stb_n_reg <= prog_stb_n_next;
      data_stb_n_reg <= data_stb_n_next;
      io_stb_n_reg   <= io_stb_n_next;
      ack_reg        <= ack_next;
    end
  end

  // APB slave: pready rises in the second access cycle, giving one fixed wait.
  assign apb_write = psel && penable && pready_reg && pwrite;
  assign apb_read  = psel && penable && !pready_reg && !pwrite;

  always_comb
  begin
    ext_wait_count_next      = ext_wait_count_reg;
    bank_switch_control_next = bank_switch_control_reg;
    wait_control_next        = wait_control_reg;
    prdata_next              = prdata_reg;
    pready_next              = psel && penable && !pready_reg;
    pslverr_next             = 1'b0;
    if (psel && penable && !pready_reg)
    begin
      case (paddr)
        EWS_ADDR_WAIT_COUNT,
        EWS_ADDR_BANK_SWITCH,
        EWS_ADDR_WAIT_CTRL,
        EWS_ADDR_STATUS:
          pslverr_next = 1'b0;
        default:
          pslverr_next = 1'b1;
      endcase
    end
    if (apb_read)
    begin
      case (paddr)
        EWS_ADDR_WAIT_COUNT:  prdata_next = {16'h0000, ext_wait_count_reg};
        EWS_ADDR_BANK_SWITCH: prdata_next = {16'h0000, bank_switch_control_reg};
        EWS_ADDR_WAIT_CTRL:   prdata_next = {16'h0000, wait_control_reg};
        EWS_ADDR_STATUS:      prdata_next = {29'h0, ready_stable_reg, gen_gated, (state_reg != EWS_ST_IDLE)};
        default:              prdata_next = 32'h00000000;
      endcase
    end
    if (apb_write)
    begin
      case (paddr)
        EWS_ADDR_WAIT_COUNT:  ext_wait_count_next      = pwdata[15:0];
        EWS_ADDR_BANK_SWITCH: bank_switch_control_next = pwdata[15:0];
        EWS_ADDR_WAIT_CTRL:   wait_control_next        = pwdata[15:0];
        default:              ext_wait_count_next      = ext_wait_count_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_wait_count_reg      <= EWS_WAIT_COUNT_RST;
      bank_switch_control_reg <= EWS_BANK_SWITCH_RST;
      wait_control_reg        <= EWS_WAIT_CTRL_RST;
      prdata_reg              <= 32'h00000000;
      pready_reg              <= 1'b0;
      pslverr_reg             <= 1'b0;
    end
    else
    begin
      ext_wait_count_reg      <= ext_wait_count_next;
      bank_switch_control_reg <= bank_switch_control_next;
      wait_control_reg        <= wait_control_next;
      prdata_reg              <= prdata_next;
      pready_reg              <= pready_next;
      pslverr_reg             <= pslverr_next;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign core_ack          = ack_reg;
  assign ext_addr          = ext_addr_reg;
  assign ext_read_n_write  = rnw_reg;
  assign prog_strobe_n     = prog_stb_n_reg;
  assign data_strobe_n     = data_stb_n_reg;
  assign io_space_strobe_n = io_stb_n_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_bank_entry;
    state_reg == EWS_ST_IDLE && core_req && !ack_reg && bank_cross;
  endsequence
  sequence s_bank_then_access;
    state_reg == EWS_ST_BANK ##1 state_reg == EWS_ST_ACCESS;
  endsequence

  AST_BANK_CYCLE: assert property (s_bank_entry |=> s_bank_then_access)
    else $error("Bank crossing did not add exactly one cycle.");
  AST_DS_TO_PS: assert property (state_reg == EWS_ST_IDLE && core_req && !ack_reg && have_prev_reg &&
      bank_switch_control_reg[EWS_DS2PS_BIT] && prev_space_reg == EWS_SP_DATA &&
      core_space == EWS_SP_PROG |=> state_reg == EWS_ST_BANK)
    else $error("Data to program move did not insert a bank cycle.");
  AST_READY_HOLD: assert property (state_reg == EWS_ST_ACCESS && !ready_stable_reg
      |=> state_reg == EWS_ST_ACCESS && !ack_reg)
    else $error("Access ended while ready was inactive.");
  AST_ACK_CAUSE: assert property ($rose(ack_reg) |-> $past(timer_expired) && $past(ready_stable_reg))
    else $error("Access ended before waits elapsed and ready was seen.");
  AST_MULT_COUNT: assert property (timer_start |-> eff_count ==
      4'(wait_fld[sel_range]) * (wait_control_reg[EWS_MULT_BIT] ? 4'h2 : 4'h1))
    else $error("Effective wait count does not follow the multiplier.");
  AST_IO_STROBE: assert property (state_reg == EWS_ST_ACCESS |->
      (io_stb_n_reg == (acc_space_reg != EWS_SP_IO)) && (rnw_reg == !acc_write_reg) &&
      ext_addr_reg[19:16] ==
      ((acc_space_reg == EWS_SP_IO) ? 4'h0 : acc_addr_reg[19:16]))
    else $error("I/O strobe or page bits wrong during access.");
  AST_GATED: assert property (gen_gated && state_reg == EWS_ST_ACCESS |-> timer_expired)
    else $error("Software waits applied although all fields are zero.");
  AST_ADDR_OUT: assert property ($rose(!prog_stb_n_reg) |-> ext_addr_reg == acc_addr_reg)
    else $error("Program address bus does not carry all twenty bits.");
  AST_APB_PULSE: assert property (pready_reg |=> !pready_reg)
    else $error("APB ready held for more than one cycle.");
endmodule

// file: tb/ews_ext_dev.sv
// Model of the external memories and port devices that answer on the ready line.
`timescale 1ns/100ps
module ews_ext_dev
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Strobes from the controller
  input  wire logic prog_strobe_n,
  input  wire logic data_strobe_n,
  input  wire logic io_space_strobe_n,
  // Access time of the modelled device, counted from its strobe while the software waits run
  input  wire logic [31:0] stall_cycles,
  // Ready answer
  output logic      ext_ready
);
  logic strobe_any;
  logic active_reg;
  int   left_reg;

  assign strobe_any = !(prog_strobe_n && data_strobe_n && io_space_strobe_n);

  // A slow device pulls ready low as soon as it sees its access begin, so the
  // controller's synchroniser has settled before the software waits run out.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_reg <= 1'b0;
      left_reg   <= 0;
      ext_ready  <= 1'b1;
    end
    else
    begin
      active_reg <= strobe_any;
      if (!active_reg && strobe_any && stall_cycles > 0)
      begin
        left_reg  <= stall_cycles;
        ext_ready <= 1'b0;
      end
      else if (left_reg > 1)
        left_reg <= left_reg - 1;
      else
      begin
        left_reg  <= 0;
        ext_ready <= 1'b1;
      end
    end
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the external bus wait-state controller.
`timescale 1ns/100ps
module testbench;
  import ews_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        core_req, core_write, core_ack, ext_read_n_write, ext_ready;
  logic        prog_strobe_n, data_strobe_n, io_space_strobe_n;
  logic [19:0] core_addr, ext_addr;
  ews_space_t  core_space;
  int          stall_cycles, n_mismatch, checks_done, last_cyc;
  logic [19:0] ad [5] = '{20'h1_0100, 20'h5_8100, 20'h0_0100, 20'h0_8100, 20'hA_4321};
  ews_space_t  sps [5] = '{EWS_SP_PROG, EWS_SP_PROG, EWS_SP_DATA, EWS_SP_DATA, EWS_SP_IO};
  int          fv [5] = '{1, 2, 3, 4, 6};

  ews_bus_ctrl i_ews_bus_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(core_req), .core_addr(core_addr), .core_space(core_space),
    .core_write(core_write), .core_ack(core_ack), .ext_addr(ext_addr),
    .ext_read_n_write(ext_read_n_write), .prog_strobe_n(prog_strobe_n),
    .data_strobe_n(data_strobe_n), .io_space_strobe_n(io_space_strobe_n), .ext_ready(ext_ready));

  ews_ext_dev i_ews_ext_dev (.pclk(pclk), .presetn(presetn), .prog_strobe_n(prog_strobe_n),
    .data_strobe_n(data_strobe_n), .io_space_strobe_n(io_space_strobe_n),
    .stall_cycles(stall_cycles), .ext_ready(ext_ready));

  always #25 pclk = ~pclk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      stop_test;
    end
  endtask

  task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic apb_rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp, "read data");
    check(e, eerr, "slave error");
  endtask

  task automatic acc(input ews_space_t sp, input logic [19:0] a, input logic w, input int exp,
                     input int bk);
    int         cyc;
    logic [2:0] strb;
    strb = (sp == EWS_SP_PROG) ? 3'b011 : (sp == EWS_SP_DATA) ? 3'b101 : 3'b110;
    @(posedge pclk);
    core_req   <= 1'b1;
    core_addr  <= a;
    core_space <= sp;
    core_write <= w;
    // The take edge counts as zero; ack is seen at the edge that closes its cycle and the request drops there.
    cyc = -1;
    while (cyc < 100 && core_ack !== 1'b1)
    begin
      @(posedge pclk);
      cyc++;
      if (cyc == 1 + bk)
      begin
        check({prog_strobe_n, data_strobe_n, io_space_strobe_n}, strb, "strobes");
        check(ext_addr, (sp == EWS_SP_IO) ? {4'h0, a[15:0]} : a, "address");
        check(ext_read_n_write, !w, "direction");
      end
    end
    core_req <= 1'b0;
    if (cyc == 100)
    begin
      n_mismatch++;
      stop_test;
    end
    check({prog_strobe_n, data_strobe_n, io_space_strobe_n}, 3'b111, "idle strobes");
    last_cyc = cyc;
    if (exp > 0)
      check(cyc, exp, "access cycles");
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, core_req, core_write} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    core_addr = 20'h0;
    core_space = EWS_SP_PROG;
    stall_cycles = 0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb_rd(EWS_ADDR_WAIT_COUNT, 32'h0000_7FFF, 1'b0);
    apb_rd(EWS_ADDR_BANK_SWITCH, 32'h0, 1'b0);
    apb_rd(EWS_ADDR_WAIT_CTRL, 32'h0, 1'b0);
    apb_rd(12'h004, 32'h0, 1'b1);
    acc(EWS_SP_DATA, 20'h0_0200, 1'b0, 9, 0);
    apb_wr(EWS_ADDR_WAIT_COUNT, 32'h0000_68D1);
    for (int m = 0; m < 2; m++)
    begin
      apb_wr(EWS_ADDR_WAIT_CTRL, m);
      for (int r = 0; r < 5; r++)
        acc(sps[r], ad[r], r[0], fv[r] * (m + 1) + 2, 0);
    end
    apb_wr(EWS_ADDR_WAIT_COUNT, 32'h0000_7FFF);
    acc(EWS_SP_PROG, 20'h1_0100, 1'b0, 16, 0);
    apb_wr(EWS_ADDR_WAIT_CTRL, 32'h0);
    stall_cycles <= 10;
    acc(EWS_SP_IO, 20'h0_0010, 1'b1, 0, 0);
    check(last_cyc > 11 && last_cyc < 22, 1'b1, "ready stall");
    stall_cycles <= 0;
    apb_wr(EWS_ADDR_WAIT_COUNT, 32'h0);
    apb_rd(EWS_ADDR_STATUS, 32'h0000_0006, 1'b0);
    acc(EWS_SP_IO, 20'h0_0010, 1'b0, 2, 0);
    apb_wr(EWS_ADDR_BANK_SWITCH, 32'hFFFF_F000);
    apb_rd(EWS_ADDR_BANK_SWITCH, 32'h0000_F000, 1'b0);
    // The access before this one was in port space, so no program bank crossing is counted yet.
    acc(EWS_SP_PROG, 20'h0_1000, 1'b0, 2, 0);
    acc(EWS_SP_PROG, 20'h0_1FFF, 1'b0, 2, 0);
    acc(EWS_SP_PROG, 20'h0_2000, 1'b1, 3, 1);
    acc(EWS_SP_DATA, 20'h0_8FFF, 1'b0, 2, 0);
    acc(EWS_SP_DATA, 20'h0_9000, 1'b1, 3, 1);
    acc(EWS_SP_IO, 20'h0_F000, 1'b0, 2, 0);
    acc(EWS_SP_IO, 20'h0_1000, 1'b0, 2, 0);
    apb_wr(EWS_ADDR_BANK_SWITCH, 32'h0000_0002);
    acc(EWS_SP_DATA, 20'h0_0100, 1'b0, 2, 0);
    acc(EWS_SP_PROG, 20'h0_0100, 1'b0, 3, 1);
    acc(EWS_SP_PROG, 20'h0_0100, 1'b0, 2, 0);
    apb_wr(EWS_ADDR_BANK_SWITCH, 32'h0);
    acc(EWS_SP_DATA, 20'h0_0100, 1'b0, 2, 0);
    acc(EWS_SP_PROG, 20'h0_0100, 1'b0, 2, 0);
    stop_test;
  end
endmodule
